// File: core/crxs_defs.svh
// Register offsets, field positions, reset values and counts for the rx status block
`ifndef CRXS_DEFS_SVH
`define CRXS_DEFS_SVH
`define CRXS_ADDR_W        8
`define CRXS_OFF_STATUS    8'h0B
`define CRXS_OFF_BITCTRL   8'h0C
`define CRXS_OFF_COLL      8'h0D
`define CRXS_OFF_IRQ_STAT  8'h20
`define CRXS_OFF_IRQ_MASK  8'h21
`define CRXS_OFF_ERROR     8'h22
`define CRXS_BIT_CIPHER    5
`define CRXS_BIT_KEEP      7
`define CRXS_BIT_COLLISION_AS_INTEGRITY_ERROR    3
`define CRXS_BIT_CPVALID   7
`define CRXS_RST_BITCTRL   8'h00
`define CRXS_RST_MASK      3'h0
`define CRXS_COLL_MAX      7'h3F
`define CRXS_IRQ_COLL      0
`define CRXS_IRQ_INTEG     1
`define CRXS_IRQ_RXDONE    2
`define CRXS_IRQ_W         3
`endif

// File: core/crxs_pkg.sv
// Types shared by the rx status block
package crxs_pkg;
    typedef enum logic [2:0] {
        CRXS_IDLE,
        CRXS_TX_WAIT,
        CRXS_TXING,
        CRXS_RX_WAIT,
        CRXS_WAIT_DATA,
        CRXS_RXING
    } crxs_state_e;
endpackage

// File: core/crxs_top.sv
// Transceiver status, receive bit framing and collision position registers
//
// The address-and-strobe port was chosen for this implementation.
module crxs_top (
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            irq_o,
    input  wire logic       tx_start_i,
    input  wire logic       tx_done_i,
    input  wire logic       rx_sof_i,
    input  wire logic       rx_end_i,
    input  wire logic       abort_i,
    input  wire logic       auth_ok_i,
    input  wire logic       bit_valid_i,
    input  wire logic       bit_data_i,
    input  wire logic       bit_coll_i,
    input  wire logic       bit_in_eof_i,
    output logic            cipher_active_o,
    output logic      [2:0] link_state_o,
    output logic            store_valid_o,
    output logic      [7:0] store_byte_o,
    output logic            byte_oriented_o
);
    `include "crxs_defs.svh"

    logic                 rst_s1_q;
    logic                 rst_n_q;
    crxs_pkg::crxs_state_e state_q;
    logic                 cipher_q;
    logic           [7:0] bitctrl_q;
    logic           [2:0] last_bits_q;
    logic           [6:0] coll_pos_q;
    logic                 coll_valid_q;
    logic                 coll_seen_q;
    logic           [9:0] bit_idx_q;
    logic           [7:0] shift_q;
    logic           [2:0] wpos_q;
    logic           [1:0] err_q;
    logic [`CRXS_IRQ_W-1:0] irq_stat_q;
    logic [`CRXS_IRQ_W-1:0] irq_mask_q;
    logic           [2:0] align;
    logic                 keep_bits;
    logic                 stored_bit;
    logic                 coll_evt;
    logic                 rx_start;
    logic           [9:0] abs_idx;
    logic [`CRXS_IRQ_W-1:0] irq_set;

    // Reset release through two stages
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    assign align      = bitctrl_q[6:4];
    assign keep_bits  = bitctrl_q[`CRXS_BIT_KEEP];
    assign rx_start   = (state_q == crxs_pkg::CRXS_WAIT_DATA) && rx_sof_i;
    // EOF collisions never count; may arrive without a data bit strobe
    assign coll_evt   = bit_coll_i && !bit_in_eof_i;
    assign stored_bit = (coll_seen_q && !keep_bits) ? 1'b0 : bit_data_i;
    assign abs_idx    = bit_idx_q + {7'h00, align};

    // Transceiver state machine
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= crxs_pkg::CRXS_IDLE;
        end else if (abort_i) begin
            state_q <= crxs_pkg::CRXS_IDLE;
        end else begin
            case (state_q)
                crxs_pkg::CRXS_IDLE: begin
                    if (tx_start_i) begin
                        state_q <= crxs_pkg::CRXS_TX_WAIT;
                    end
                end
                crxs_pkg::CRXS_TX_WAIT: begin
                    state_q <= crxs_pkg::CRXS_TXING;
                end
                crxs_pkg::CRXS_TXING: begin
                    if (tx_done_i) begin
                        state_q <= crxs_pkg::CRXS_RX_WAIT;
                    end
                end
                crxs_pkg::CRXS_RX_WAIT: begin
                    state_q <= crxs_pkg::CRXS_WAIT_DATA;
                end
                crxs_pkg::CRXS_WAIT_DATA: begin
                    if (rx_sof_i) begin
                        state_q <= crxs_pkg::CRXS_RXING;
                    end
                end
                crxs_pkg::CRXS_RXING: begin
                    if (rx_end_i) begin
                        state_q <= crxs_pkg::CRXS_IDLE;
                    end
                end
                default: begin
                    state_q <= crxs_pkg::CRXS_IDLE;
                end
            endcase
        end
    end

    // State coding for software; 100b has no state mapped to it
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            link_state_o <= 3'h0;
        end else begin
            case (state_q)
                crxs_pkg::CRXS_TX_WAIT:   link_state_o <= 3'h1;
                crxs_pkg::CRXS_TXING:     link_state_o <= 3'h3;
                crxs_pkg::CRXS_RX_WAIT:   link_state_o <= 3'h5;
                crxs_pkg::CRXS_WAIT_DATA: link_state_o <= 3'h6;
                crxs_pkg::CRXS_RXING:     link_state_o <= 3'h7;
                default:                  link_state_o <= 3'h0;
            endcase
        end
    end

    // Cipher enable: auth sets, host may only clear
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cipher_q <= 1'b0;
        end else if (auth_ok_i) begin
            cipher_q <= 1'b1;
        end else if (wr_i && addr_i == `CRXS_OFF_STATUS && !wdata_i[`CRXS_BIT_CIPHER]) begin
            cipher_q <= 1'b0;
        end
    end

    // Framing control, writable fields only; last bits come from decoder
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bitctrl_q <= `CRXS_RST_BITCTRL;
        end else if (wr_i && addr_i == `CRXS_OFF_BITCTRL) begin
            bitctrl_q <= {wdata_i[7:3], 3'h0};
        end
    end

    // Valid bits of last byte: cleared at start, loaded at bit-oriented end
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            last_bits_q <= 3'h0;
        end else if (rx_start) begin
            last_bits_q <= 3'h0;
        end else if (state_q == crxs_pkg::CRXS_RXING && rx_end_i && align != 3'h0) begin
            last_bits_q <= wpos_q;
        end
    end

    // Bit assembly: write position starts at offset, wraps per byte
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wpos_q        <= 3'h0;
            shift_q       <= 8'h00;
            store_valid_o <= 1'b0;
            store_byte_o  <= 8'h00;
        end else begin
            store_valid_o <= 1'b0;
            if (rx_start) begin
                wpos_q  <= align;
                shift_q <= 8'h00;
            end else if (state_q == crxs_pkg::CRXS_RXING && bit_valid_i) begin
                wpos_q <= wpos_q + 3'h1;
                shift_q[wpos_q] <= stored_bit;
                if (wpos_q == 3'h7) begin
                    store_valid_o <= 1'b1;
                    store_byte_o  <= {stored_bit, shift_q[6:0]};
                    shift_q       <= 8'h00;
                end
            end else if (state_q == crxs_pkg::CRXS_RXING && rx_end_i && wpos_q != 3'h0) begin
                store_valid_o <= 1'b1;
                store_byte_o  <= shift_q;
            end
        end
    end

    // Collision tracking; index counts data bits only
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bit_idx_q    <= 10'h000;
            coll_seen_q  <= 1'b0;
            coll_pos_q   <= 7'h00;
            coll_valid_q <= 1'b0;
        end else if (rx_start) begin
            bit_idx_q    <= 10'h000;
            coll_seen_q  <= 1'b0;
            coll_pos_q   <= 7'h00;
            coll_valid_q <= 1'b0;
        end else if (state_q == crxs_pkg::CRXS_RXING && bit_valid_i) begin
            if (bit_idx_q != 10'h3FF) begin
                bit_idx_q <= bit_idx_q + 10'h001;
            end
            if (coll_evt && !coll_seen_q) begin
                coll_seen_q <= 1'b1;
                // Beyond eight bytes the position cannot be shown
                if (abs_idx <= {3'h0, `CRXS_COLL_MAX}) begin
                    coll_pos_q   <= abs_idx[6:0];
                    coll_valid_q <= 1'b1;
                end
            end
        end
    end

    // Error flags: collision and integrity, cleared at reception start
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            err_q <= 2'h0;
        end else if (rx_start) begin
            err_q <= 2'h0;
        end else if (state_q == crxs_pkg::CRXS_RXING && coll_evt) begin
            err_q[0] <= 1'b1;
            if (bitctrl_q[`CRXS_BIT_COLLISION_AS_INTEGRITY_ERROR]) begin
                err_q[1] <= 1'b1;
            end
        end
    end

    assign irq_set[`CRXS_IRQ_COLL]   = state_q == crxs_pkg::CRXS_RXING && coll_evt;
    assign irq_set[`CRXS_IRQ_INTEG]  = irq_set[`CRXS_IRQ_COLL] && bitctrl_q[`CRXS_BIT_COLLISION_AS_INTEGRITY_ERROR];
    assign irq_set[`CRXS_IRQ_RXDONE] = state_q == crxs_pkg::CRXS_RXING && rx_end_i;

    // Sticky events; a new event beats a same-cycle clear
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_stat_q <= '0;
            irq_mask_q <= `CRXS_RST_MASK;
        end else begin
            if (wr_i && addr_i == `CRXS_OFF_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~wdata_i[`CRXS_IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
            if (wr_i && addr_i == `CRXS_OFF_IRQ_MASK) begin
                irq_mask_q <= wdata_i[`CRXS_IRQ_W-1:0];
            end
        end
    end

    // Registered outputs and read data one cycle after strobe
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_o         <= 8'h00;
            irq_o           <= 1'b0;
            cipher_active_o <= 1'b0;
            byte_oriented_o <= 1'b1;
        end else begin
            irq_o           <= |(irq_stat_q & irq_mask_q);
            cipher_active_o <= cipher_q;
            byte_oriented_o <= (align == 3'h0);
            rdata_o         <= 8'h00;
            if (rd_i) begin
                case (addr_i)
                    `CRXS_OFF_STATUS:   rdata_o <= {2'h0, cipher_q, 2'h0, link_state_o};
                    `CRXS_OFF_BITCTRL:  rdata_o <= {bitctrl_q[7:3], last_bits_q};
                    `CRXS_OFF_COLL:     rdata_o <= {coll_valid_q, coll_pos_q};
                    `CRXS_OFF_IRQ_STAT: rdata_o <= {5'h00, irq_stat_q};
                    `CRXS_OFF_IRQ_MASK: rdata_o <= {5'h00, irq_mask_q};
                    `CRXS_OFF_ERROR:    rdata_o <= {6'h00, err_q};
                    default:            rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // Self-checks on framing, collision and status behaviour
    chk_valid_only_coll: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        coll_valid_q |-> coll_seen_q && coll_pos_q <= `CRXS_COLL_MAX)
        else $error("collision valid without collision");
    chk_state_no_four: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        link_state_o != 3'h4)
        else $error("link state shows unused code");
    chk_cipher_set_auth: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        $rose(cipher_q) |-> $past(auth_ok_i))
        else $error("cipher set without authenticate");
    chk_cipher_clear: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        wr_i && addr_i == `CRXS_OFF_STATUS && !wdata_i[5] && !auth_ok_i |=> !cipher_q)
        else $error("cipher not cleared by write");
    chk_zero_after_coll: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        state_q == crxs_pkg::CRXS_RXING && bit_valid_i && coll_seen_q && !keep_bits
        |=> shift_q[$past(wpos_q)] == 1'b0 || store_valid_o)
        else $error("bit after collision not zeroed");
    chk_first_position: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        rx_start |=> wpos_q == $past(align))
        else $error("first bit position wrong");
    chk_wrap_store: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        state_q == crxs_pkg::CRXS_RXING && bit_valid_i && wpos_q == 3'h7 && !rx_start
        |=> store_valid_o ##0 wpos_q == 3'h0)
        else $error("no wrap after bit seven");
    chk_integ_from_coll: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        state_q == crxs_pkg::CRXS_RXING && coll_evt && bitctrl_q[3] |=> err_q == 2'h3)
        else $error("collision flags not raised");
    chk_last_bits_clr: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        rx_start |=> last_bits_q == 3'h0)
        else $error("last bits not cleared");
    chk_byte_mode_flag: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        byte_oriented_o == ($past(align) == 3'h0))
        else $error("byte mode flag wrong");
    chk_coll_err_set: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        state_q == crxs_pkg::CRXS_RXING && coll_evt |=> err_q[0])
        else $error("collision flag not raised");
    chk_coll_err_cause: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        $rose(err_q[0]) |-> $past(bit_coll_i && !bit_in_eof_i))
        else $error("collision flag without collision");
    chk_integ_needs_ctrl: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        $rose(err_q[1]) |-> $past(bitctrl_q[`CRXS_BIT_COLLISION_AS_INTEGRITY_ERROR]))
        else $error("integrity error without control");
    chk_last_bits_hold: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        state_q == crxs_pkg::CRXS_RXING && rx_end_i && align == 3'h0 |=> $stable(last_bits_q))
        else $error("last bits loaded in byte mode");
    chk_first_coll_kept: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        coll_valid_q && !rx_start |=> $stable(coll_pos_q))
        else $error("collision position overwritten");
    chk_status_reserved: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        rd_i && addr_i == `CRXS_OFF_STATUS |=> rdata_o[7:6] == 2'h0 && rdata_o[4:3] == 2'h0)
        else $error("reserved status bits set");
endmodule

// File: tb/crxs_card_model.sv
// Card side model: frame events, received data bits, authentication outcome
module crxs_card_model (
    input  wire logic clock_i,
    output logic      tx_start_o,
    output logic      tx_done_o,
    output logic      rx_sof_o,
    output logic      rx_end_o,
    output logic      abort_o,
    output logic      auth_ok_o,
    output logic      bit_valid_o,
    output logic      bit_data_o,
    output logic      bit_coll_o,
    output logic      bit_in_eof_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] ev_q = 6'h00;
    // Strobes: tx start, tx done, frame start, frame end, abort, auth
    assign {auth_ok_o, abort_o, rx_end_o, rx_sof_o, tx_done_o, tx_start_o} = ev_q;
    initial begin
        bit_valid_o  = 1'b0;
        bit_data_o   = 1'b0;
        bit_coll_o   = 1'b0;
        bit_in_eof_o = 1'b0;
    end
    // One-cycle strobe launched just after an edge
    task automatic pulse(input int k);
        @(posedge clock_i);
        ev_q[k] <= 1'b1;
        @(posedge clock_i);
        ev_q[k] <= 1'b0;
    endtask
    // Reader sends, card answers; framing symbols never reach the bit stream
    task automatic start_rx();
        pulse(0);
        repeat (2) @(posedge clock_i);
        pulse(1);
        repeat (2) @(posedge clock_i);
        pulse(2);
    endtask
    // Data bits LSB first with an idle cycle between, as RF bits are slow
    task automatic send_bits(input int n, input logic [127:0] d, input int coll);
        for (int i = 0; i < n; i++) begin
            @(posedge clock_i);
            bit_valid_o <= 1'b1;
            bit_data_o  <= d[i];
            bit_coll_o  <= (i == coll);
            @(posedge clock_i);
            bit_valid_o <= 1'b0;
            bit_coll_o  <= 1'b0;
            bit_data_o  <= ~d[i]; // Released line shows no stale value
        end
    endtask
    // Frame end, optionally with a collision inside the end symbol
    task automatic end_rx(input logic eof);
        if (eof) begin
            @(posedge clock_i);
            bit_coll_o   <= 1'b1;
            bit_in_eof_o <= 1'b1;
            @(posedge clock_i);
            bit_coll_o   <= 1'b0;
            bit_in_eof_o <= 1'b0;
        end
        pulse(3);
    endtask
    // Transmit start cut short by an abort
    task automatic abort_tx();
        pulse(0);
        pulse(4);
    endtask
    task automatic auth();
        pulse(5);
    endtask
endmodule

// File: tb/crxs_tb_top.sv
// Self-checking bench for the rx status, bit framing and collision registers
`include "crxs_defs.svh"
module crxs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic [7:0] addr_i  = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i    = 1'b0;
    logic       rd_i    = 1'b0;
    logic [7:0] rdata_o, store_byte_o, rv;
    logic [2:0] link_state_o;
    logic       irq_o, cipher_active_o, store_valid_o, byte_oriented_o;
    logic       tx_start_i, tx_done_i, rx_sof_i, rx_end_i, abort_i, auth_ok_i;
    logic       bit_valid_i, bit_data_i, bit_coll_i, bit_in_eof_i;
    logic [7:0] seen = 8'h00;
    logic [7:0] stored [$];
    int         error_cnt = 0;
    int         n_checks = 0;
    always #10 clock_i = ~clock_i;
    crxs_top crxs_top_i (.clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
        .tx_start_i, .tx_done_i, .rx_sof_i, .rx_end_i, .abort_i, .auth_ok_i, .bit_valid_i,
        .bit_data_i, .bit_coll_i, .bit_in_eof_i, .cipher_active_o, .link_state_o,
        .store_valid_o, .store_byte_o, .byte_oriented_o);
    crxs_card_model crxs_card_model_i (.clock_i, .tx_start_o(tx_start_i), .tx_done_o(tx_done_i),
        .rx_sof_o(rx_sof_i), .rx_end_o(rx_end_i), .abort_o(abort_i), .auth_ok_o(auth_ok_i),
        .bit_valid_o(bit_valid_i), .bit_data_o(bit_data_i), .bit_coll_o(bit_coll_i),
        .bit_in_eof_o(bit_in_eof_i));
    // Sampled mid-cycle so the edge's updates have landed
    always @(negedge clock_i) begin
        if (store_valid_o === 1'b1)
            stored.push_back(store_byte_o);
        if (rst_b_i === 1'b1)
            seen[link_state_o] = 1'b1;
    end
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Register bus: one-cycle strobes, read data only in the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(name, rv, exp);
    endtask
    task automatic t_reset();
        rdc("status", `CRXS_OFF_STATUS, 8'h00);
        rdc("bitctrl", `CRXS_OFF_BITCTRL, `CRXS_RST_BITCTRL);
        rdc("coll", `CRXS_OFF_COLL, 8'h00);
        rdc("unmapped", 8'h30, 8'h00);
        chk("byte mode", {7'h00, byte_oriented_o}, 8'h01);
    endtask
    // Host can only clear the cipher; reserved bits stay zero
    task automatic t_cipher();
        wr(`CRXS_OFF_STATUS, 8'hFF);
        rdc("status set", `CRXS_OFF_STATUS, 8'h00);
        crxs_card_model_i.auth();
        rdc("status auth", `CRXS_OFF_STATUS, 8'h20);
        chk("cipher on", {7'h00, cipher_active_o}, 8'h01);
        wr(`CRXS_OFF_STATUS, 8'hDF);
        rdc("status clr", `CRXS_OFF_STATUS, 8'h00);
        chk("cipher off", {7'h00, cipher_active_o}, 8'h00);
    endtask
    // Offset 4, zeroing after a collision on the fourth bit, 13 bits
    task automatic t_coll();
        wr(`CRXS_OFF_BITCTRL, 8'h4F);
        rdc("bitctrl ro", `CRXS_OFF_BITCTRL, 8'h48);
        chk("bit mode", {7'h00, byte_oriented_o}, 8'h00);
        stored.delete();
        crxs_card_model_i.start_rx();
        crxs_card_model_i.send_bits(13, {128{1'b1}}, 3);
        crxs_card_model_i.end_rx(1'b0);
        tick(4);
        chk("stored n", 8'(stored.size()), 8'h03);
        chk("byte0", {stored[0][7:4], 4'h0}, 8'hF0);
        chk("byte1", stored[1], 8'h00);
        rdc("last bits", `CRXS_OFF_BITCTRL, 8'h49);
        rdc("coll pos", `CRXS_OFF_COLL, 8'h87);
        rdc("errors", `CRXS_OFF_ERROR, 8'h03);
        rdc("irq stat", `CRXS_OFF_IRQ_STAT, 8'h07);
    endtask
    task automatic t_irq();
        chk("irq masked", {7'h00, irq_o}, 8'h00);
        wr(`CRXS_OFF_IRQ_MASK, 8'h01);
        tick(3);
        chk("irq on", {7'h00, irq_o}, 8'h01);
        wr(`CRXS_OFF_IRQ_STAT, 8'h01);
        tick(3);
        chk("irq off", {7'h00, irq_o}, 8'h00);
        rdc("irq w1c", `CRXS_OFF_IRQ_STAT, 8'h06);
        wr(`CRXS_OFF_IRQ_STAT, 8'h06);
    endtask
    // Offset 7 wraps the second bit; collision in the end symbol is ignored
    task automatic t_wrap();
        wr(`CRXS_OFF_BITCTRL, 8'hF0);
        stored.delete();
        crxs_card_model_i.start_rx();
        rdc("last clr", `CRXS_OFF_BITCTRL, 8'hF0);
        crxs_card_model_i.send_bits(10, 128'h2CB, 200);
        crxs_card_model_i.end_rx(1'b1);
        tick(4);
        chk("wrap b0", {stored[0][7], 7'h00}, 8'h80);
        chk("wrap b1", stored[1], 8'h65);
        chk("wrap b2", {7'h00, stored[2][0]}, 8'h01);
        rdc("last bits", `CRXS_OFF_BITCTRL, 8'hF1);
        rdc("no coll", `CRXS_OFF_COLL, 8'h00);
        rdc("eof coll", `CRXS_OFF_ERROR, 8'h00);
    endtask
    // Byte mode, collision at index 64 is past the reportable range
    task automatic t_range();
        wr(`CRXS_OFF_BITCTRL, 8'h80);
        stored.delete();
        crxs_card_model_i.start_rx();
        chk("byte mode", {7'h00, byte_oriented_o}, 8'h01);
        crxs_card_model_i.send_bits(66, {128{1'b1}}, 64);
        crxs_card_model_i.end_rx(1'b0);
        tick(4);
        chk("stored n", 8'(stored.size()), 8'h09);
        chk("kept", stored[8], 8'h03);
        rd(`CRXS_OFF_COLL);
        chk("range", {rv[7], 7'h00}, 8'h00);
        rdc("errors", `CRXS_OFF_ERROR, 8'h01);
        rdc("last kept", `CRXS_OFF_BITCTRL, 8'h80);
    endtask
    task automatic t_abort();
        int k;
        crxs_card_model_i.abort_tx();
        #1;
        for (k = 0; k < 50 && link_state_o !== 3'h0; k++)
            tick(1);
        chk("abort idle", {5'h00, link_state_o}, 8'h00);
        chk("link codes", seen, 8'hEB);
        if (k == 50)
            final_report();
    endtask
    // Reset in mid-run drops the cipher and the framing control
    task automatic t_midrst();
        crxs_card_model_i.auth();
        wr(`CRXS_OFF_BITCTRL, 8'hF8);
        @(posedge clock_i);
        rst_b_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        t_reset();
        chk("cipher rst", {7'h00, cipher_active_o}, 8'h00);
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        t_reset();
        t_cipher();
        t_coll();
        t_irq();
        t_wrap();
        t_range();
        t_abort();
        t_midrst();
        final_report();
    end
endmodule
